// ### verilog/timer_unit_pkg.sv
// constants shared by the two-timer configuration block and its bench monitor.
// assumes a 32-bit apb register bus with word-aligned byte addresses.
package timer_unit_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [11:0] FIRST_RUN_ADDR = 12'h000;
    localparam logic [11:0] FIRST_MODE_ADDR = 12'h008;
    localparam logic [11:0] CLOCK_ENABLE_ADDR = 12'h050;
    localparam logic [11:0] UNIT_MODE_ADDR = 12'h054;
    localparam logic [11:0] SECOND_RUN_ADDR = 12'h100;
    localparam logic [11:0] SECOND_MODE_ADDR = 12'h108;
    localparam logic [11:0] FIRST_COUNT_ADDR = 12'h200;
    localparam logic [11:0] SECOND_COUNT_ADDR = 12'h204;

    // timer_clock_enable fields
    localparam int SECOND_GATE_BIT = 7;
    localparam int FIRST_GATE_BIT = 6;
    localparam int HALT_KEEP_BIT = 5;

    // unit_mode_config fields
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int MODE_RSVD_LSB = 6;
    localparam int MODE_RSVD_W = 2;

    // run register field
    localparam int RUN_BIT = 0;

    // count clock select field of each timer's mode register
    localparam int CLK_SEL_LSB = 0;
    localparam int CLK_SEL_W = 4;

    localparam logic [2:0] MODE_SECOND_ONLY = 3'h1;
    localparam logic [2:0] MODE_FIRST_ONLY = 3'h2;
    localparam logic [2:0] MODE_BOTH = 3'h3;
    localparam logic [2:0] MODE_LOCK_CH0 = 3'h6;
    localparam logic [2:0] MODE_LOCK_ALL = 3'h7;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam int PRESCALE_W = 16;

endpackage

// ### verilog/up_counter.sv
// one timer's up-counter: counts prescaled ticks while running.
// assumes tick, run and freeze come from logic on mclk.
`timescale 1ns/10ps
module up_counter #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic run,
    input wire logic tick,
    input wire logic freeze,
    output logic [CNT_W-1:0] count
);

    generate
        if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
            $error("up_counter width must be 1 to 32");
        end
    endgenerate

    logic [CNT_W-1:0] next_count;

    // a stopped counter is held at zero, a frozen one keeps its value
    assign next_count = !run ? '0 : (tick && !freeze) ? count + 1'b1 : count;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule

// ### verilog/timer_unit_config.sv
// global configuration of a two-timer unit: clock gates, debug-halt freeze,
// unit mode decode, count clock sharing, run control and the two up-counters.
// assumes an apb master on mclk; dbg_halt and the update events come from mclk logic.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
module timer_unit_config #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timer_unit_pkg::ADDR_W-1:0] paddr,
    input wire logic [timer_unit_pkg::DATA_W-1:0] pwdata,
    output logic [timer_unit_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dbg_halt,
    input wire logic first_own_ch0_update,
    input wire logic second_output_channel_zero_update,
    input wire logic second_any_update,
    output logic first_output_channel_zero_update,
    output logic second_timer_clock_gate,
    output logic first_timer_clock_gate,
    output logic first_pulse_mode,
    output logic second_pulse_mode,
    output logic interlocked,
    output logic first_prescaled_clock,
    output logic second_prescaled_clock,
    output logic first_running,
    output logic second_running,
    output logic [CNT_W-1:0] first_count,
    output logic [CNT_W-1:0] second_count
);

    generate
        if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
            $error("timer_unit_config counter width must be 1 to 32");
        end
    endgenerate

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [2:0] clock_enable;
    logic [timer_unit_pkg::MODE_W-1:0] unit_mode;
    logic [timer_unit_pkg::MODE_RSVD_W-1:0] mode_rsvd;
    logic [timer_unit_pkg::CLK_SEL_W-1:0] first_clk_sel;
    logic [timer_unit_pkg::CLK_SEL_W-1:0] second_clk_sel;
    logic first_run_bit;
    logic second_run_bit;

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    wire [11:0] addr12 = paddr[11:0];
    wire hit_first_run = addr12 == timer_unit_pkg::FIRST_RUN_ADDR;
    wire hit_first_mode = addr12 == timer_unit_pkg::FIRST_MODE_ADDR;
    wire hit_enable = addr12 == timer_unit_pkg::CLOCK_ENABLE_ADDR;
    wire hit_unit_mode = addr12 == timer_unit_pkg::UNIT_MODE_ADDR;
    wire hit_second_run = addr12 == timer_unit_pkg::SECOND_RUN_ADDR;
    wire hit_second_mode = addr12 == timer_unit_pkg::SECOND_MODE_ADDR;
    wire hit_first_count = addr12 == timer_unit_pkg::FIRST_COUNT_ADDR;
    wire hit_second_count = addr12 == timer_unit_pkg::SECOND_COUNT_ADDR;
    wire mapped = hit_first_run | hit_first_mode | hit_enable | hit_unit_mode
        | hit_second_run | hit_second_mode | hit_first_count | hit_second_count;
    // counter readback is read-only, so a write there is refused too
    wire refused = !mapped || (pwrite && (hit_first_count || hit_second_count));

    // no wait state: read data is captured at the setup edge so prdata is a flop
    wire setup_phase = psel && !penable;
    wire write_take = psel && penable && pwrite && !refused;

    assign pready = psel && penable;
    assign pslverr = psel && penable && refused;

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    wire mode_second_only = unit_mode == timer_unit_pkg::MODE_SECOND_ONLY;
    wire mode_first_only = unit_mode == timer_unit_pkg::MODE_FIRST_ONLY;
    wire mode_both = unit_mode == timer_unit_pkg::MODE_BOTH;
    wire mode_lock_ch0 = unit_mode == timer_unit_pkg::MODE_LOCK_CH0;
    wire mode_lock_all = unit_mode == timer_unit_pkg::MODE_LOCK_ALL;

    assign interlocked = mode_lock_ch0 || mode_lock_all;
    // reserved and prohibited codes leave both timers idle
    assign first_pulse_mode = mode_first_only || mode_both || interlocked;
    assign second_pulse_mode = mode_second_only || mode_both || interlocked;

    // first timer's ch0 update source
    assign first_output_channel_zero_update = mode_lock_ch0 ? second_output_channel_zero_update
        : mode_lock_all ? second_any_update
        : first_own_ch0_update;

    // ---------------------------------------------------------------
    // clock gates and debug freeze
    // ---------------------------------------------------------------
    assign second_timer_clock_gate = clock_enable[2];
    assign first_timer_clock_gate = clock_enable[1];
    wire halt_keep = clock_enable[0];
    // only the up-counters stop; the prescalers keep their phase
    wire freeze = dbg_halt && !halt_keep;

    // ---------------------------------------------------------------
    // prescalers: tick once every 2**select cycles of mclk
    // ---------------------------------------------------------------
    logic [timer_unit_pkg::PRESCALE_W-1:0] first_pre;
    logic [timer_unit_pkg::PRESCALE_W-1:0] second_pre;
    wire [timer_unit_pkg::PRESCALE_W-1:0] first_mask =
        timer_unit_pkg::PRESCALE_W'((17'h1 << first_clk_sel) - 17'h1);
    wire [timer_unit_pkg::PRESCALE_W-1:0] second_mask =
        timer_unit_pkg::PRESCALE_W'((17'h1 << second_clk_sel) - 17'h1);
    wire first_tick_raw = (first_pre & first_mask) == first_mask;
    wire second_tick_raw = (second_pre & second_mask) == second_mask;

    wire first_tick = first_timer_clock_gate && first_tick_raw;
    // interlocked: second timer takes the first timer's prescaled clock
    wire second_tick = second_timer_clock_gate && (interlocked ? first_tick_raw : second_tick_raw);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            first_pre <= '0;
            second_pre <= '0;
            first_prescaled_clock <= 1'b0;
            second_prescaled_clock <= 1'b0;
        end else begin
            // a gated-off timer's prescaler holds still
            if (first_timer_clock_gate) begin
                first_pre <= first_pre + 1'b1;
            end
            if (second_timer_clock_gate) begin
                second_pre <= second_pre + 1'b1;
            end
            first_prescaled_clock <= first_tick;
            second_prescaled_clock <= second_tick;
        end
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clock_enable <= 3'h0;
            unit_mode <= timer_unit_pkg::REG_RESET[timer_unit_pkg::MODE_W-1:0];
            mode_rsvd <= timer_unit_pkg::REG_RESET[timer_unit_pkg::MODE_RSVD_W-1:0];
            first_clk_sel <= timer_unit_pkg::REG_RESET[timer_unit_pkg::CLK_SEL_W-1:0];
            second_clk_sel <= timer_unit_pkg::REG_RESET[timer_unit_pkg::CLK_SEL_W-1:0];
            first_run_bit <= 1'b0;
            second_run_bit <= 1'b0;
        end else if (write_take) begin
            if (hit_enable) begin
                clock_enable <= {pwdata[timer_unit_pkg::SECOND_GATE_BIT],
                    pwdata[timer_unit_pkg::FIRST_GATE_BIT], pwdata[timer_unit_pkg::HALT_KEEP_BIT]};
            end
            if (hit_unit_mode) begin
                unit_mode <= pwdata[timer_unit_pkg::MODE_LSB +: timer_unit_pkg::MODE_W];
                mode_rsvd <= pwdata[timer_unit_pkg::MODE_RSVD_LSB +: timer_unit_pkg::MODE_RSVD_W];
            end
            if (hit_first_mode) begin
                first_clk_sel <= pwdata[timer_unit_pkg::CLK_SEL_LSB +: timer_unit_pkg::CLK_SEL_W];
            end
            if (hit_second_mode) begin
                second_clk_sel <= pwdata[timer_unit_pkg::CLK_SEL_LSB +: timer_unit_pkg::CLK_SEL_W];
            end
            if (hit_first_run) begin
                first_run_bit <= pwdata[timer_unit_pkg::RUN_BIT];
            end
            if (hit_second_run) begin
                second_run_bit <= pwdata[timer_unit_pkg::RUN_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // run control and counters
    // ---------------------------------------------------------------
    assign first_running = first_run_bit && first_pulse_mode;
    // interlocked: second run bit is ignored, second follows the first
    assign second_running = interlocked ? first_running : (second_run_bit && second_pulse_mode);

    up_counter #(
        .CNT_W(CNT_W)
    ) u_first_counter (
        .mclk(mclk),
        .nrst(nrst),
        .run(first_running),
        .tick(first_tick),
        .freeze(freeze),
        .count(first_count)
    );

    up_counter #(
        .CNT_W(CNT_W)
    ) u_second_counter (
        .mclk(mclk),
        .nrst(nrst),
        .run(second_running),
        .tick(second_tick),
        .freeze(freeze),
        .count(second_count)
    );

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    logic [31:0] enable_view;
    logic [31:0] mode_view;
    logic [31:0] first_sel_view;
    logic [31:0] second_sel_view;
    logic [31:0] read_mux;

    always_comb begin
        enable_view = timer_unit_pkg::REG_RESET;
        enable_view[timer_unit_pkg::SECOND_GATE_BIT] = clock_enable[2];
        enable_view[timer_unit_pkg::FIRST_GATE_BIT] = clock_enable[1];
        enable_view[timer_unit_pkg::HALT_KEEP_BIT] = clock_enable[0];
        mode_view = timer_unit_pkg::REG_RESET;
        mode_view[timer_unit_pkg::MODE_LSB +: timer_unit_pkg::MODE_W] = unit_mode;
        mode_view[timer_unit_pkg::MODE_RSVD_LSB +: timer_unit_pkg::MODE_RSVD_W] = mode_rsvd;
        first_sel_view = timer_unit_pkg::REG_RESET;
        first_sel_view[timer_unit_pkg::CLK_SEL_LSB +: timer_unit_pkg::CLK_SEL_W] = first_clk_sel;
        second_sel_view = timer_unit_pkg::REG_RESET;
        second_sel_view[timer_unit_pkg::CLK_SEL_LSB +: timer_unit_pkg::CLK_SEL_W] = second_clk_sel;
    end

    // run registers are write-only and read as zero
    assign read_mux = hit_enable ? enable_view
        : hit_unit_mode ? mode_view
        : hit_first_mode ? first_sel_view
        : hit_second_mode ? second_sel_view
        : hit_first_count ? 32'(first_count)
        : hit_second_count ? 32'(second_count)
        : timer_unit_pkg::REG_RESET;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= timer_unit_pkg::REG_RESET;
        end else if (setup_phase) begin
            prdata <= (pwrite || refused) ? timer_unit_pkg::REG_RESET : read_mux;
        end
    end

endmodule

// ### tb/tuc_monitor.sv
// concurrent checks on the two-timer configuration block's ports.
// assumes it is bound into timer_unit_config; one clock mclk, nrst async active low.
`timescale 1ns/10ps
module tuc_monitor #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timer_unit_pkg::ADDR_W-1:0] paddr,
    input wire logic [timer_unit_pkg::DATA_W-1:0] pwdata,
    input wire logic first_own_ch0_update,
    input wire logic second_output_channel_zero_update,
    input wire logic second_any_update,
    input wire logic first_output_channel_zero_update,
    input wire logic second_timer_clock_gate,
    input wire logic first_timer_clock_gate,
    input wire logic first_pulse_mode,
    input wire logic second_pulse_mode,
    input wire logic interlocked,
    input wire logic first_prescaled_clock,
    input wire logic second_prescaled_clock,
    input wire logic first_running,
    input wire logic second_running,
    input wire logic [CNT_W-1:0] first_count
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic en_wr = psel && penable && pwrite && paddr == timer_unit_pkg::CLOCK_ENABLE_ADDR;
    wire logic mode_wr = psel && penable && pwrite && paddr == timer_unit_pkg::UNIT_MODE_ADDR;
    // mode code as software last wrote it, so the checks do not lean on the design's decode
    logic [2:0] mode_seen;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode_seen <= 3'h0;
        end else if (mode_wr) begin
            mode_seen <= pwdata[2:0];
        end
    end
    wire logic lock_seen = mode_seen == timer_unit_pkg::MODE_LOCK_CH0 || mode_seen == timer_unit_pkg::MODE_LOCK_ALL;
    gate_write_only_a: assert property (
        $changed(second_timer_clock_gate) || $changed(first_timer_clock_gate) |-> $past(en_wr))
        else $error("clock gate moved without an enable write");
    second_gate_a: assert property (
        en_wr |=> second_timer_clock_gate == $past(pwdata[7])) else $error("second gate not bit 7");
    first_gate_a: assert property (
        en_wr |=> first_timer_clock_gate == $past(pwdata[6])) else $error("first gate not bit 6");
    first_tick_gate_a: assert property (
        first_prescaled_clock |-> $past(first_timer_clock_gate)) else $error("tick while gated off");
    count_clear_a: assert property (
        !first_running |=> first_count == '0) else $error("stopped counter not cleared");
    count_step_a: assert property (
        first_count != $past(first_count) && first_count != '0
        |-> first_count == $past(first_count) + 1'b1 && first_prescaled_clock) else $error("bad count step");
    lock_pulse_a: assert property (
        interlocked == lock_seen && (!interlocked || (first_pulse_mode && second_pulse_mode)))
        else $error("interlock without pulse modes");
    ch0_select_a: assert property (
        first_output_channel_zero_update == (mode_seen == timer_unit_pkg::MODE_LOCK_CH0
        ? second_output_channel_zero_update : mode_seen == timer_unit_pkg::MODE_LOCK_ALL
        ? second_any_update : first_own_ch0_update)) else $error("ch0 update source wrong");
    lockstep_run_a: assert property (
        interlocked |-> second_running == first_running) else $error("second not in lockstep");
    shared_clock_a: assert property (
        interlocked && $past(interlocked) && $past(first_timer_clock_gate && second_timer_clock_gate)
        |-> second_prescaled_clock == first_prescaled_clock) else $error("second clock not shared");
    cover property (en_wr);
    cover property (interlocked && first_running);
    cover property (first_prescaled_clock && !second_prescaled_clock);
endmodule
bind timer_unit_config tuc_monitor #(.CNT_W(CNT_W)) mon (.*);

// ### tb/testbench.sv
// self-checking bench for the two-timer configuration block over apb.
// assumes a 100 MHz mclk; the bench drives every port itself.
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; $display("mismatch at %0t: %h %h", $time, a, e); end end
module testbench;
    logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, dbg_halt = 0;
    logic first_own_ch0_update = 0, second_output_channel_zero_update = 0, second_any_update = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, first_output_channel_zero_update, second_timer_clock_gate;
    logic first_timer_clock_gate, first_pulse_mode, second_pulse_mode, interlocked;
    logic first_prescaled_clock, second_prescaled_clock, first_running, second_running;
    logic [15:0] first_count, second_count;
    int bad_count = 0, n_compared = 0, en_m, mode_m;
    always #5 mclk = ~mclk;
    timer_unit_config uut (.*);
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 16) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    // counts prescaled ticks of both timers over n cycles
    task automatic pulses(input int n, output int f, output int s);
        f = 0;
        s = 0;
        repeat (n) begin
            @(posedge mclk);
            #1;
            f += first_prescaled_clock;
            s += second_prescaled_clock;
        end
    endtask
    initial begin
        int c0, f, s;
        logic [2:0] m;
        void'($urandom(79780));
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        xfer(0, 12'h050, 0); `CHK(rd, 32'h0)
        xfer(0, 12'h054, 0); `CHK(rd, 32'h0)
        xfer(0, 12'h000, 0); `CHK(rd, 32'h0)
        en_m = $urandom;
        xfer(1, 12'h050, en_m);
        xfer(0, 12'h050, 0); `CHK(rd, en_m & 32'he0)
        `CHK(second_timer_clock_gate, en_m[7])
        `CHK(first_timer_clock_gate, en_m[6])
        xfer(1, 12'h200, 32'h5); `CHK(err, 1'b1)
        $display("register test done");
        for (int k = 0; k < 8; k++) begin
            m = k[2:0];
            mode_m = ($urandom & 32'hc0) | k;
            xfer(1, 12'h054, mode_m);
            xfer(0, 12'h054, 0); `CHK(rd, mode_m)
            {first_own_ch0_update, second_output_channel_zero_update, second_any_update} <= 3'($urandom);
            @(posedge mclk);
            #1; `CHK(first_pulse_mode, m == 2 || m == 3 || m >= 6)
            `CHK(second_pulse_mode, m == 1 || m == 3 || m >= 6)
            `CHK(interlocked, m >= 6)
            `CHK(first_output_channel_zero_update, m == 6 ? second_output_channel_zero_update
                : m == 7 ? second_any_update : first_own_ch0_update)
        end
        $display("mode test done");
        xfer(1, 12'h050, 32'hc0);
        xfer(1, 12'h054, 3);
        xfer(1, 12'h008, 0);
        xfer(1, 12'h108, 1);
        pulses(16, f, s); `CHK(f, 16)
        `CHK(s, 8)
        xfer(1, 12'h000, 1);
        @(posedge mclk);
        #1 c0 = first_count;
        repeat (10) @(posedge mclk);
        #1; `CHK(first_count, 16'(c0 + 10))
        `CHK(second_count, 16'h0)
        // halt is raised on an edge like every other input; the freeze bites one edge later
        @(posedge mclk);
        dbg_halt <= 1'b1;
        @(posedge mclk);
        #1 c0 = first_count;
        repeat (5) @(posedge mclk);
        #1; `CHK(first_count, 16'(c0))
        xfer(1, 12'h050, 32'he0);
        @(posedge mclk);
        #1 c0 = first_count;
        repeat (5) @(posedge mclk);
        #1; `CHK(first_count, 16'(c0 + 5))
        @(posedge mclk);
        dbg_halt <= 1'b0;
        xfer(1, 12'h000, 0);
        @(posedge mclk);
        #1; `CHK(first_count, 16'h0)
        $display("counter test done");
        // second run bit left at zero and a slow clock select: both must be overridden
        xfer(1, 12'h054, 7);
        xfer(1, 12'h108, 3);
        xfer(1, 12'h000, 1);
        repeat (7) @(posedge mclk);
        #1; `CHK(first_count, 16'h7)
        `CHK(second_count, 16'h7)
        xfer(1, 12'h008, 1);
        pulses(16, f, s); `CHK(s, 8)
        xfer(1, 12'h050, 32'h40);
        pulses(16, f, s); `CHK(s, 0)
        xfer(1, 12'h054, 0);
        @(posedge mclk);
        #1; `CHK(first_running, 1'b0)
        $display("interlock test done");
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        tally_and_finish();
    end
endmodule
